// ==== bench/boot_memory_model.sv ====
// Purpose: serial boot memory seen from the loader
// Assumes: chip enable active low, tied to the completion line
// Notes:   word source comes from the bench by index
`timescale 1ns/1ns
module boot_memory_model (
  // link side
  input  wire logic        config_clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        enable_n_in,
  // word source
  input  wire logic [31:0] word_in,
  output logic             data_out,
  output logic [9:0]       word_count_out
);
  logic [4:0] bit_index;
  logic       filler;
  // ==========================================================================
  // one bit per rising config clock, msb first, any rate
  always_ff @(posedge config_clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_index <= 5'h00;
      word_count_out <= 10'h000;
      filler <= 1'b0;
    end else begin
      filler <= ~filler;
      if (!enable_n_in) begin
        bit_index <= bit_index + 5'h01;
        if (bit_index == 5'h1f) word_count_out <= word_count_out + 10'h001;
      end
    end
  end
  // reset by init, enabled by completion line, changing pattern when off
  assign data_out = enable_n_in ? filler : word_in[5'h1f - bit_index];
endmodule

// ==== bench/loader_checker.sv ====
// Purpose: port checker of the config loader
// Assumes: strap changes only while reset_in is high
// Notes:   bound to every loader instance
`timescale 1ns/1ns
module loader_checker
  import loader_pkg::*;
#(
  parameter longint OSC_HZ = OSC_HZ_DEFAULT
) (
  // clocks and reset
  input wire logic                 clock_in,
  input wire logic                 reset_in,
  input wire logic                 osc_clock_in,
  // link pins
  input wire logic                 config_clock_out,
  input wire logic                 serial_data_in,
  input wire logic                 serial_data_out,
  input wire logic                 init_n_out,
  input wire logic                 done_in,
  input wire logic                 done_out,
  input wire logic                 done_oe_out,
  // straps, rate, words, status
  input wire logic                 active_completion_drive_in,
  input wire logic                 own_config_done_in,
  input wire logic [RATE_BITS-1:0] clock_rate_setting_in,
  input wire logic                 rate_load_in,
  input wire logic                 rate_busy_out,
  input wire logic [WORD_BITS-1:0] config_word_out,
  input wire logic                 word_valid_out,
  input wire logic                 word_ready_in,
  input wire logic                 forward_limit_out,
  input wire logic                 line_done_out
);
  // ==========================================================================
  // system side
  chk_init_high: assert property (@(posedge clock_in) disable iff (reset_in)
    !reset_in |=> init_n_out) else $error("init pin low outside reset");
  chk_done_low: assert property (@(posedge clock_in) disable iff (reset_in)
    !own_config_done_in |=> done_oe_out && !done_out) else $error("done not held low");
  chk_done_release: assert property (@(posedge clock_in) disable iff (reset_in)
    own_config_done_in && !active_completion_drive_in |=> !done_oe_out)
    else $error("done not released");
  chk_done_drive: assert property (@(posedge clock_in) disable iff (reset_in)
    own_config_done_in && active_completion_drive_in |=> done_oe_out && done_out)
    else $error("done not driven high");
  chk_busy_set: assert property (@(posedge clock_in) disable iff (reset_in)
    rate_load_in && !rate_busy_out |=> rate_busy_out) else $error("rate load not taken");
  chk_busy_bound: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(rate_busy_out) |-> ##[1:60] !rate_busy_out) else $error("rate never applied");
  chk_word_hold: assert property (@(posedge clock_in) disable iff (reset_in)
    word_valid_out && !word_ready_in |=> word_valid_out && $stable(config_word_out))
    else $error("word dropped while stalled");
  // ==========================================================================
  // oscillator side
  chk_clock_high: assert property (@(posedge osc_clock_in) disable iff (reset_in)
    $rose(config_clock_out) |=> config_clock_out) else $error("short high phase");
  chk_clock_low: assert property (@(posedge osc_clock_in) disable iff (reset_in)
    $fell(config_clock_out) |=> !config_clock_out) else $error("short low phase");
  chk_high_bound: assert property (@(posedge osc_clock_in) disable iff (reset_in)
    $rose(config_clock_out) |-> ##[1:8] !config_clock_out) else $error("clock too slow");
  chk_fwd_idle: assert property (@(posedge osc_clock_in) disable iff (reset_in)
    !own_config_done_in |-> serial_data_out) else $error("serial out busy while loading");
  cov_word: cover property (@(posedge clock_in) word_valid_out && word_ready_in);
  cov_stall: cover property (@(posedge clock_in) word_valid_out && !word_ready_in);
  cov_rate: cover property (@(posedge clock_in) rate_load_in && !rate_busy_out);
  cov_fwd: cover property (@(posedge osc_clock_in) own_config_done_in && $rose(config_clock_out));
endmodule

bind master_serial_config_loader loader_checker #(.OSC_HZ(OSC_HZ)) chk (
  .clock_in(clock_in), .reset_in(reset_in), .osc_clock_in(osc_clock_in),
  .config_clock_out(config_clock_out), .serial_data_in(serial_data_in),
  .serial_data_out(serial_data_out), .init_n_out(init_n_out), .done_in(done_in),
  .done_out(done_out), .done_oe_out(done_oe_out),
  .active_completion_drive_in(active_completion_drive_in),
  .own_config_done_in(own_config_done_in), .clock_rate_setting_in(clock_rate_setting_in),
  .rate_load_in(rate_load_in), .rate_busy_out(rate_busy_out),
  .config_word_out(config_word_out), .word_valid_out(word_valid_out),
  .word_ready_in(word_ready_in), .forward_limit_out(forward_limit_out),
  .line_done_out(line_done_out));

// ==== bench/master_serial_config_loader_tb_top.sv ====
// Purpose: self-checking bench of the config loader
// Assumes: oscillator at 30 ns, system clock at 100 ns
// Notes:   random words and consumer stalls, fixed seed
`timescale 1ns/1ns
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (got), (exp)); end end
module master_serial_config_loader_tb_top
  import loader_pkg::*;
;
  logic                 clock_in, reset_in, osc_clock, strap, own_done, chain_hold;
  logic                 rate_load, ready, stall, fwd_on, din_prev;
  logic [RATE_BITS-1:0] rate_setting;
  wire logic            config_clock, serial_in, serial_out, init_n, done_line, done_o;
  wire logic            done_oe, busy, valid, limit, line_done;
  wire logic [31:0]     word;
  logic [31:0]          sent [0:1023];
  logic [9:0]           mem_count;
  int                   fail_count, total_checks, got_words, cycles, rises, r0, seed;
  // ==========================================================================
  // clocks, completion wire with pull-up and a held-low chained part
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  initial begin
    osc_clock = 1'b0;
    #7;
    forever #15 osc_clock = ~osc_clock;
  end
  assign done_line = done_oe ? done_o : !chain_hold;
  master_serial_config_loader #(.OSC_HZ(33_333_333)) dut (
    .clock_in(clock_in), .reset_in(reset_in), .osc_clock_in(osc_clock),
    .config_clock_out(config_clock), .serial_data_in(serial_in), .serial_data_out(serial_out),
    .init_n_out(init_n), .done_in(done_line), .done_out(done_o), .done_oe_out(done_oe),
    .active_completion_drive_in(strap), .own_config_done_in(own_done),
    .clock_rate_setting_in(rate_setting), .rate_load_in(rate_load), .rate_busy_out(busy),
    .config_word_out(word), .word_valid_out(valid), .word_ready_in(ready),
    .forward_limit_out(limit), .line_done_out(line_done));
  boot_memory_model mem (
    .config_clock_in(config_clock), .reset_n_in(init_n), .enable_n_in(done_line),
    .word_in(sent[mem_count]), .data_out(serial_in), .word_count_out(mem_count));
  // ==========================================================================
  // consumer, timeout, forwarding watch
  always @(negedge clock_in) ready = !stall && ($urandom % 4 != 0);
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      report_and_stop();
    end else if (reset_in) begin
      got_words = 0;
    end else if (valid === 1'b1 && ready === 1'b1) begin
      `CHECK(word, sent[got_words[9:0]])
      got_words++;
    end
  end
  always @(posedge config_clock) begin
    rises++;
    din_prev = serial_in;
    if (fwd_on) begin
      #5;
      `CHECK(serial_out, din_prev)
    end
  end
  // ==========================================================================
  // tasks
  task measure(input int exp_ns);
    time a;
    begin
      @(posedge config_clock);
      a = $time;
      repeat (3) @(posedge config_clock);
      `CHECK(($time - a) / 3 > exp_ns - 36 && ($time - a) / 3 < exp_ns + 36, 1'b1)
    end
  endtask
  task load_rate(input logic [RATE_BITS-1:0] r);
    int n;
    begin
      @(negedge clock_in);
      rate_setting = r;
      rate_load = 1'b1;
      @(negedge clock_in);
      rate_load = 1'b0;
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
        @(negedge clock_in);
        n++;
      end
      `CHECK(busy, 1'b0)
    end
  endtask
  task report_and_stop();
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // ==========================================================================
  // main sequence
  logic [RATE_BITS-1:0] rates [4] = '{6'h00, 6'h02, 6'h05, 6'h3f};
  int                   periods [4] = '{250, 250, 200, 120};
  initial begin
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    rises = 0;
    reset_in = 1'b1;
    {strap, own_done, chain_hold, rate_load, stall, fwd_on} = 6'h00;
    rate_setting = 6'h00;
    seed = $urandom(70067);
    for (int i = 0; i < 1024; i++) sent[i] = $urandom;
    repeat (5) @(negedge clock_in);
    `CHECK({init_n, done_oe, done_o, serial_out, config_clock}, 5'h0a)
    `CHECK({valid, busy, limit}, 3'h0)
    @(negedge clock_in);
    reset_in = 1'b0;
    @(negedge clock_in);
    `CHECK(init_n, 1'b1)
    $display("test reset done");
    measure(400);
    $display("test powerup rate done");
    for (int i = 0; i < 4; i++) begin
      load_rate(rates[i]);
      repeat (2) @(posedge config_clock);
      measure(periods[i]);
    end
    $display("test rate steps done");
    stall = 1'b1;
    repeat (400) @(negedge clock_in);
    r0 = rises;
    repeat (100) @(negedge clock_in);
    `CHECK(rises, r0)
    `CHECK(valid, 1'b1)
    stall = 1'b0;
    repeat (300) @(negedge clock_in);
    `CHECK(got_words > 12, 1'b1)
    $display("test stall done");
    chain_hold = 1'b1;
    own_done = 1'b1;
    repeat (3) @(negedge clock_in);
    `CHECK({done_oe, line_done}, 2'h0)
    repeat (80) @(negedge clock_in);
    r0 = got_words;
    fwd_on = 1'b1;
    repeat (60) @(negedge clock_in);
    fwd_on = 1'b0;
    `CHECK(got_words, r0)
    chain_hold = 1'b0;
    repeat (8) @(negedge clock_in);
    `CHECK(line_done, 1'b1)
    `CHECK(limit, 1'b0)
    $display("test forwarding done");
    reset_in = 1'b1;
    own_done = 1'b0;
    strap = 1'b1;
    repeat (6) @(negedge clock_in);
    reset_in = 1'b0;
    own_done = 1'b1;
    repeat (3) @(negedge clock_in);
    `CHECK({done_oe, done_o}, 2'h3)
    $display("test completion drive done");
    report_and_stop();
  end
endmodule

// ==== design/loader_pkg.sv ====
// Purpose: shared constants and types of the master-serial configuration loader
// Assumes: system clock of 10 MHz, free-running internal oscillator as link clock
// Notes:   rates are given in MHz on the rate setting, powerup rate in kHz

package loader_pkg;

  // ==========================================================================
  // data path
  localparam int WORD_BITS  = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int BIT_INDEX_BITS = 5;
  localparam logic [BIT_INDEX_BITS-1:0] LAST_BIT = 5'h1f;

  // ==========================================================================
  // forwarding length
  localparam int COUNT_BITS = 20;
  localparam logic [COUNT_BITS-1:0] FORWARD_MAX_WORDS = 20'hfffff;

  // ==========================================================================
  // clock rates
  localparam longint SYS_CLOCK_HZ     = 10_000_000;
  localparam longint OSC_HZ_DEFAULT   = 33_333_333;
  localparam longint POWERUP_RATE_KHZ = 2500;
  localparam int     RATE_BITS        = 6;
  localparam logic [RATE_BITS-1:0] DEFAULT_RATE_MHZ = 6'h04;
  localparam logic [RATE_BITS-1:0] MAX_RATE_MHZ     = 6'h3c;
  localparam int     PHASE_BITS       = 24;
  localparam int     PRODUCT_BITS     = 30;

  // ==========================================================================
  // crossings
  localparam int SYNC_STAGES = 3;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {LOAD, FORWARD, HALT} link_mode_t;

  typedef struct packed {
    logic [WORD_BITS-1:0] data;
  } config_word_t;

  typedef struct packed {
    logic level;
    logic enable;
  } pin_drive_t;

endpackage

// ==== design/master_serial_config_loader.sv ====
// Purpose: master-serial loader: makes the config clock, gathers words, forwards
// Assumes: serial data changes only after config clock edges made here
// Notes:   link logic runs on the oscillator clock, the rest on clock_in

`timescale 1ns/1ns

// ============================================================================
// three-stage synchroniser, a change counts once stages two and three agree
module sync_stage #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] data_in,
  output logic      [WIDTH-1:0] data_out
);
  import loader_pkg::*;

  logic [SYNC_STAGES-1:0] pipe [WIDTH];

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock_in) begin
      pipe[i] <= {pipe[i][SYNC_STAGES-2:0], data_in[i]};
    end
    always_ff @(posedge clock_in) begin
      if (reset_in) begin
        data_out[i] <= 1'b0;
      end else if (pipe[i][1] == pipe[i][2]) begin
        data_out[i] <= pipe[i][2];
      end
    end
  end
endmodule

// ============================================================================
// dual-clock fifo with gray pointers
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // write side
  input  wire logic             wr_clock_in,
  input  wire logic             wr_reset_in,
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  // read side
  input  wire logic             rd_clock_in,
  input  wire logic             rd_reset_in,
  output logic                  rd_valid_out,
  output logic      [WIDTH-1:0] rd_data_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least four");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_bin;
  logic [AW:0]      wr_gray;
  logic [AW:0]      rd_bin;
  logic [AW:0]      rd_gray;
  logic [AW:0]      wr_gray_at_rd;
  logic [AW:0]      rd_gray_at_wr;
  logic [AW:0]      next_wr_bin;
  logic [AW:0]      next_rd_bin;
  logic             push;
  logic             pop;

  assign wr_ready_out = wr_gray != {~rd_gray_at_wr[AW:AW-1], rd_gray_at_wr[AW-2:0]};
  assign rd_valid_out = rd_gray != wr_gray_at_rd;
  assign rd_data_out  = mem[rd_bin[AW-1:0]];
  assign push         = wr_valid_in & wr_ready_out;
  assign pop          = rd_valid_out & rd_ready_in;
  assign next_wr_bin  = wr_bin + (AW+1)'(1);
  assign next_rd_bin  = rd_bin + (AW+1)'(1);

  always_ff @(posedge wr_clock_in) begin
    if (push) begin
      mem[wr_bin[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge wr_clock_in) begin
    if (wr_reset_in) begin
      wr_bin  <= '0;
      wr_gray <= '0;
    end else if (push) begin
      wr_bin  <= next_wr_bin;
      wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
    end
  end

  always_ff @(posedge rd_clock_in) begin
    if (rd_reset_in) begin
      rd_bin  <= '0;
      rd_gray <= '0;
    end else if (pop) begin
      rd_bin  <= next_rd_bin;
      rd_gray <= next_rd_bin ^ (next_rd_bin >> 1);
    end
  end

  sync_stage #(.WIDTH(AW+1)) u_wr_to_rd (
    .clock_in (rd_clock_in),
    .reset_in (rd_reset_in),
    .data_in  (wr_gray),
    .data_out (wr_gray_at_rd)
  );

  sync_stage #(.WIDTH(AW+1)) u_rd_to_wr (
    .clock_in (wr_clock_in),
    .reset_in (wr_reset_in),
    .data_in  (rd_gray),
    .data_out (rd_gray_at_wr)
  );
endmodule

// ============================================================================
// How it works
// (R01) a data bit is taken at each rising config clock edge made here
// (R02) boot memory shifts one bit per rising config clock edge we drive
// (R03) once loaded, incoming bits leave on serial out after each rising edge
// (R04) forwarding stops after 1,048,575 words of 32 bits
// (R05) config clock comes from the internal oscillator and is driven out
// (R06) rate starts slow, may only rise, lower settings are refused
// (R07) powerup rate is 2.5 MHz until a rate setting arrives
// (R08) a rate setting of zero selects 4 MHz
// (R09) rate settings above 60 MHz are clamped to 60 MHz
// (R10) boot memory and chained parts must keep up with the chosen rate
// (R11) this end is the chain master and makes the clock for all
// (R12) init pin resets the boot memory, completion pin enables it
// (R13) completion pin is driven high only when the strap asks for it
// (R14) a new rate takes effect only at a clock period boundary
module master_serial_config_loader
  import loader_pkg::*;
#(
  parameter longint OSC_HZ = OSC_HZ_DEFAULT
) (
  // system clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 reset_in,
  // internal oscillator, clocks the link logic
  input  wire logic                 osc_clock_in,
  // boot memory and chain pins
  output logic                      config_clock_out,
  input  wire logic                 serial_data_in,
  output logic                      serial_data_out,
  output logic                      init_n_out,
  input  wire logic                 done_in,
  output logic                      done_out,
  output logic                      done_oe_out,
  // straps and fabric status
  input  wire logic                 active_completion_drive_in,
  input  wire logic                 own_config_done_in,
  // rate setting
  input  wire logic [RATE_BITS-1:0] clock_rate_setting_in,
  input  wire logic                 rate_load_in,
  output logic                      rate_busy_out,
  // loaded words toward the fabric
  output logic [WORD_BITS-1:0]      config_word_out,
  output logic                      word_valid_out,
  input  wire logic                 word_ready_in,
  // status
  output logic                      forward_limit_out,
  output logic                      line_done_out
);

  localparam logic [PRODUCT_BITS-1:0] STEP_PER_MHZ =
    PRODUCT_BITS'((longint'(1) << PHASE_BITS) * 1_000_000 / OSC_HZ);
  localparam logic [PHASE_BITS-1:0] MAX_STEP = PHASE_BITS'(1 << (PHASE_BITS - 2));
  localparam logic [PHASE_BITS-1:0] POWERUP_STEP =
    PHASE_BITS'(longint'(STEP_PER_MHZ) * POWERUP_RATE_KHZ / 1000);

  if (OSC_HZ < 4 * DEFAULT_RATE_MHZ * 1_000_000) begin : g_bad_osc
    $error("oscillator too slow for the default rate");
  end

  function automatic logic [PHASE_BITS-1:0] rate_step(input logic [RATE_BITS-1:0] mhz);
    logic [RATE_BITS-1:0]    m;
    logic [PRODUCT_BITS-1:0] p;
    m = (mhz == '0) ? DEFAULT_RATE_MHZ : mhz; // [R08]
    m = (m > MAX_RATE_MHZ) ? MAX_RATE_MHZ : m; // [R09]
    p = PRODUCT_BITS'(m) * STEP_PER_MHZ;
    return (p > PRODUCT_BITS'(MAX_STEP)) ? MAX_STEP : p[PHASE_BITS-1:0];
  endfunction

  // ==========================================================================
  // system side
  logic                 drive_strap;
  logic                 forward_request;
  logic                 rate_req;
  logic [RATE_BITS-1:0] rate_value;
  logic [2:0]           sys_sync;
  logic                 rate_accept;
  config_word_t         fifo_word;
  logic                 fifo_valid;
  logic                 fifo_take;
  pin_drive_t           next_done;

  assign rate_accept = rate_load_in & ~rate_busy_out;
  assign fifo_take   = ~word_valid_out | word_ready_in;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      drive_strap <= active_completion_drive_in;
      init_n_out  <= 1'b0; // [R12]
    end else begin
      init_n_out  <= 1'b1;
    end
  end

  always_comb begin
    next_done = '{level: 1'b0, enable: 1'b1}; // [R12]
    if (own_config_done_in) begin
      next_done = '{level: 1'b1, enable: drive_strap}; // [R13]
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      done_out    <= 1'b0;
      done_oe_out <= 1'b1;
    end else begin
      done_out    <= next_done.level;
      done_oe_out <= next_done.enable;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rate_req      <= 1'b0;
      rate_value    <= '0;
      rate_busy_out <= 1'b0;
    end else if (rate_accept) begin
      rate_req      <= ~rate_req;
      rate_value    <= clock_rate_setting_in;
      rate_busy_out <= 1'b1;
    end else begin
      rate_busy_out <= sys_sync[2] != rate_req;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      forward_request   <= 1'b0;
      forward_limit_out <= 1'b0;
      line_done_out     <= 1'b0;
    end else begin
      forward_request   <= own_config_done_in;
      forward_limit_out <= sys_sync[1];
      line_done_out     <= sys_sync[0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      word_valid_out  <= 1'b0;
      config_word_out <= '0;
    end else if (fifo_take) begin
      word_valid_out  <= fifo_valid;
      if (fifo_valid) begin
        config_word_out <= fifo_word.data;
      end
    end
  end

  // ==========================================================================
  // link side
  logic [SYNC_STAGES-1:0]  link_reset_pipe;
  logic                    link_reset;
  logic [1:0]              link_sync;
  logic [PHASE_BITS-1:0]   phase;
  logic [PHASE_BITS-1:0]   step;
  logic [PHASE_BITS-1:0]   pending_step;
  logic                    step_pending;
  logic [PHASE_BITS-1:0]   candidate;
  logic                    rate_seen;
  logic                    rate_ack;
  logic [PHASE_BITS:0]     next_sum;
  logic                    rise;
  logic                    stall;
  logic                    sample;
  logic                    boundary;
  link_mode_t              mode;
  logic [WORD_BITS-1:0]    shift;
  logic [BIT_INDEX_BITS-1:0] bit_index;
  logic [COUNT_BITS-1:0]   word_count;
  config_word_t            link_word;
  logic                    word_pending;
  logic                    wr_ready;

  assign link_reset       = link_reset_pipe[SYNC_STAGES-1];
  assign next_sum         = {1'b0, phase} + {1'b0, step};
  assign rise             = ~phase[PHASE_BITS-1] & next_sum[PHASE_BITS-1];
  assign stall            = rise & word_pending & ~wr_ready;
  assign sample           = rise & ~stall;
  assign boundary         = next_sum[PHASE_BITS] & ~stall;
  assign config_clock_out = phase[PHASE_BITS-1]; // [R05] [R11]
  assign candidate        = rate_step(rate_value);

  always_ff @(posedge osc_clock_in) begin
    link_reset_pipe <= {link_reset_pipe[SYNC_STAGES-2:0], reset_in};
  end

  always_ff @(posedge osc_clock_in) begin
    if (link_reset) begin
      phase <= '0;
      step  <= POWERUP_STEP; // [R07]
    end else if (!stall) begin
      phase <= next_sum[PHASE_BITS-1:0];
      if (boundary && step_pending) begin
        step <= pending_step; // [R14]
      end
    end
  end

  always_ff @(posedge osc_clock_in) begin
    if (link_reset) begin
      rate_seen    <= 1'b0;
      rate_ack     <= 1'b0;
      step_pending <= 1'b0;
      pending_step <= '0;
    end else begin
      rate_ack <= rate_seen;
      if (boundary) begin
        step_pending <= 1'b0;
      end
      if (link_sync[1] != rate_seen) begin
        rate_seen <= link_sync[1];
        if (candidate > (step_pending ? pending_step : step)) begin // [R06]
          pending_step <= candidate;
          step_pending <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge osc_clock_in) begin
    if (link_reset) begin
      mode            <= LOAD;
      shift           <= '0;
      bit_index       <= '0;
      word_count      <= '0;
      link_word       <= '0;
      word_pending    <= 1'b0;
      serial_data_out <= 1'b1;
    end else begin
      if (word_pending && wr_ready) begin
        word_pending <= 1'b0;
      end
      if (sample) begin
        unique case (mode)
          LOAD: begin
            if (link_sync[0] && bit_index == '0 && !word_pending) begin
              mode            <= FORWARD;
              serial_data_out <= serial_data_in; // [R03]
              bit_index       <= bit_index + 5'h01;
            end else begin
              shift     <= {shift[WORD_BITS-2:0], serial_data_in}; // [R01] [R02]
              bit_index <= bit_index + 5'h01;
              if (bit_index == LAST_BIT) begin
                link_word.data <= {shift[WORD_BITS-2:0], serial_data_in};
                word_pending   <= 1'b1;
              end
            end
          end
          FORWARD: begin
            serial_data_out <= serial_data_in; // [R03]
            bit_index       <= bit_index + 5'h01;
            if (bit_index == LAST_BIT) begin
              word_count <= word_count + 20'h00001;
              if (word_count == FORWARD_MAX_WORDS - 20'h00001) begin
                mode <= HALT; // [R04]
              end
            end
          end
          HALT: begin
            serial_data_out <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // crossings
  sync_stage #(.WIDTH(2)) u_to_link (
    .clock_in (osc_clock_in),
    .reset_in (link_reset),
    .data_in  ({rate_req, forward_request}),
    .data_out (link_sync)
  );

  sync_stage #(.WIDTH(3)) u_to_sys (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .data_in  ({rate_ack, mode == HALT, done_in}),
    .data_out (sys_sync)
  );

  word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wr_clock_in  (osc_clock_in),
    .wr_reset_in  (link_reset),
    .wr_valid_in  (word_pending),
    .wr_data_in   (link_word),
    .wr_ready_out (wr_ready),
    .rd_clock_in  (clock_in),
    .rd_reset_in  (reset_in),
    .rd_valid_out (fifo_valid),
    .rd_data_out  (fifo_word),
    .rd_ready_in  (fifo_take)
  );

endmodule
